// ===== rtl/pmu_reset_retention_ctrl.sv
/*
  Power-management reset and retention control registers: crystal settle
  counter with interrupt, retention regulator overrides, reset cause flags,
  boot security flags and rail discharge controls behind AXI4-Lite.
  Assumes aresetn is the power-on reset, event inputs are single-cycle
  pulses synchronous to aclk and lp_tick marks each low-power clock cycle.
*/
// Implementation choice: the AXI4-Lite slave port.
// Overview of operation
// - Count LP ticks to delay, then interrupt; zero disables
// - Regulator enable is software bit OR machine enable
// - Reference hold is software bit OR machine hold
// - Power-on, pin, software cause flags; reset reads one
// - Watchdog flag set by watchdog and power-on
// - Debug flag set by debug request and power-on
// - Boot flags write-one-only, cleared by power-on only
// - Debug block flag disables debug port completely
// - Authenticated-boot flag reports secure boot support
// - Auto-discharge rail on pin reset when enabled
// - Immediate discharge bit discharges rail at once
// - Discharge is immediate bit OR automatic discharge
`timescale 1ns/1ps

module pmu_reset_retention_ctrl (
  input  wire logic                                   aclk,
  input  wire logic                                   aresetn,
  input  wire logic [31:0]                            s_axi_awaddr,
  input  wire logic [2:0]                             s_axi_awprot,
  input  wire logic                                   s_axi_awvalid,
  output logic                                        s_axi_awready,
  input  wire logic [31:0]                            s_axi_wdata,
  input  wire logic [3:0]                             s_axi_wstrb,
  input  wire logic                                   s_axi_wvalid,
  output logic                                        s_axi_wready,
  output logic [1:0]                                  s_axi_bresp,
  output logic                                        s_axi_bvalid,
  input  wire logic                                   s_axi_bready,
  input  wire logic [31:0]                            s_axi_araddr,
  input  wire logic [2:0]                             s_axi_arprot,
  input  wire logic                                   s_axi_arvalid,
  output logic                                        s_axi_arready,
  output logic [31:0]                                 s_axi_rdata,
  output logic [1:0]                                  s_axi_rresp,
  output logic                                        s_axi_rvalid,
  input  wire logic                                   s_axi_rready,
  input  wire logic                                   lp_tick,
  input  wire logic                                   crystal_enable,
  input  wire pmu_reset_retention_pkg::retention_ctrl_t sm_retention,
  output pmu_reset_retention_pkg::retention_ctrl_t      retention_out,
  input  wire pmu_reset_retention_pkg::reset_events_t   reset_events,
  input  wire logic                                   pin_reset_active,
  output pmu_reset_retention_pkg::rail_discharge_t      rail_discharge,
  input  wire logic                                   debugger_enable,
  output logic                                        debug_port_allow,
  output logic                                        secure_boot_supported,
  output logic                                        crystal_settled_interrupt
);
  import pmu_reset_retention_pkg::*;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [DELAY_W-1:0]  crystal_settle_count_q;
  logic [OVR_W-1:0]    override_q;
  logic [CAUSE_W-1:0]  cause_q;
  logic [CAUSE_W-1:0]  cause_d;
  logic [SECURE_W-1:0] secure_q;
  logic [SECURE_W-1:0] secure_d;
  logic [RAIL_N-1:0]   rail_auto_q;
  logic [RAIL_N-1:0]   rail_now_q;
  logic [IRQ_W-1:0]    irq_status_q;
  logic [IRQ_W-1:0]    irq_status_d;
  logic [IRQ_W-1:0]    irq_mask_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  wire                logic                wr_fire;
  wire                logic [DECODE_W-1:0] wr_idx;
  wire                logic [REG_W-1:0]    wmask;
  wire                logic [REG_W-1:0]    wbits;
  wire                logic                wr_delay;
  wire                logic                wr_ovr;
  wire                logic                wr_cause;
  wire                logic                wr_secure;
  wire                logic                wr_auto;
  wire                logic                wr_now;
  wire                logic                wr_irq_st;
  wire                logic                wr_irq_mk;
  wire                logic                wr_hit;

  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign s_axi_wready  = s_axi_awready;
  assign wr_fire       = s_axi_awready;
  assign wr_idx        = s_axi_awaddr[DECODE_LSB +: DECODE_W];
  assign wmask         = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign wbits         = s_axi_wdata[REG_W-1:0] & wmask;

  assign wr_delay  = wr_fire & (wr_idx == CRYSTAL_READY_DELAY_IDX[DECODE_W-1:0]);
  assign wr_ovr    = wr_fire & (wr_idx == RETENTION_REG_OVERRIDE_IDX[DECODE_W-1:0]);
  assign wr_cause  = wr_fire & (wr_idx == RESET_CAUSE_FLAGS_IDX[DECODE_W-1:0]);
  assign wr_secure = wr_fire & (wr_idx == BOOT_SECURITY_FLAGS_IDX[DECODE_W-1:0]);
  assign wr_auto   = wr_fire & (wr_idx == RAIL_AUTO_DISCHARGE_IDX[DECODE_W-1:0]);
  assign wr_now    = wr_fire & (wr_idx == RAIL_IMMEDIATE_DISCHARGE_IDX[DECODE_W-1:0]);
  assign wr_irq_st = wr_fire & (wr_idx == IRQ_STATUS_IDX[DECODE_W-1:0]);
  assign wr_irq_mk = wr_fire & (wr_idx == IRQ_MASK_IDX[DECODE_W-1:0]);
  assign wr_hit    = wr_delay | wr_ovr | wr_cause | wr_secure | wr_auto | wr_now | wr_irq_st | wr_irq_mk;

  // Byte-lane merge of a stored field with new write data
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old_v);
    merge = (old_v & ~wmask) | wbits;
  endfunction

  // ----------------------------------------------------------------------
  // Crystal settle counter
  // ----------------------------------------------------------------------
  logic [DELAY_W-1:0] settle_cnt_q;
  logic               settle_done_q;
  logic               crystal_en_q;
  wire  logic         settle_hit;

  assign settle_hit = crystal_enable & crystal_en_q & ~settle_done_q & lp_tick
                    & (crystal_settle_count_q != DELAY_NO_IRQ)
                    & (settle_cnt_q + 8'h01 == crystal_settle_count_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt_q  <= DELAY_RST;
      settle_done_q <= 1'b0;
      crystal_en_q  <= 1'b0;
    end else begin
      crystal_en_q <= crystal_enable;
      if (!crystal_enable || !crystal_en_q) begin
        settle_cnt_q  <= DELAY_RST;
        settle_done_q <= 1'b0;
      end else if (lp_tick && !settle_done_q) begin
        settle_cnt_q  <= settle_cnt_q + 8'h01;
        settle_done_q <= settle_hit;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sticky flags: hardware sets win over software writes
  // ----------------------------------------------------------------------
  wire  logic [CAUSE_W-1:0] cause_set;
  wire  logic [REG_W-1:0]   cause_w;

  assign cause_set[CAUSE_POWER_ON] = 1'b0;
  assign cause_set[CAUSE_PIN]      = reset_events.pin_reset;
  assign cause_set[CAUSE_SOFTWARE] = reset_events.software_reset;
  assign cause_set[CAUSE_WATCHDOG] = reset_events.watchdog_reset;
  assign cause_set[CAUSE_DEBUG]    = reset_events.debug_reset_request;

  assign cause_w  = merge({{(REG_W-CAUSE_W){1'b0}}, cause_q});
  assign cause_d  = (wr_cause ? cause_w[CAUSE_W-1:0] : cause_q) | cause_set;
  assign secure_d = secure_q | (wr_secure ? wbits[SECURE_W-1:0] : SECURE_RST);
  assign irq_status_d = (irq_status_q & ~(wr_irq_st ? wbits[IRQ_W-1:0] : IRQ_RST))
                      | {settle_hit};

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [REG_W-1:0] delay_w;
  logic [REG_W-1:0] ovr_w;
  logic [REG_W-1:0] auto_w;
  logic [REG_W-1:0] now_w;
  logic [REG_W-1:0] mask_w;

  assign delay_w = merge({{(REG_W-DELAY_W){1'b0}}, crystal_settle_count_q});
  assign ovr_w   = merge({{(REG_W-OVR_W){1'b0}}, override_q});
  assign auto_w  = merge({{(REG_W-RAIL_N){1'b0}}, rail_auto_q});
  assign now_w   = merge({{(REG_W-RAIL_N){1'b0}}, rail_now_q});
  assign mask_w  = merge({{(REG_W-IRQ_W){1'b0}}, irq_mask_q});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_settle_count_q <= DELAY_RST;
      override_q             <= OVR_RST;
      cause_q                <= CAUSE_RST;
      secure_q               <= SECURE_RST;
      rail_auto_q            <= RAIL_RST;
      rail_now_q             <= RAIL_RST;
      irq_status_q           <= IRQ_RST;
      irq_mask_q             <= IRQ_RST;
    end else begin
      if (wr_delay) crystal_settle_count_q <= delay_w[DELAY_W-1:0];
      if (wr_ovr)   override_q             <= ovr_w[OVR_W-1:0];
      if (wr_auto)  rail_auto_q            <= auto_w[RAIL_N-1:0];
      if (wr_now)   rail_now_q             <= now_w[RAIL_N-1:0];
      if (wr_irq_mk) irq_mask_q            <= mask_w[IRQ_W-1:0];
      cause_q      <= cause_d;
      secure_q     <= secure_d;
      irq_status_q <= irq_status_d;
    end
  end

  // ----------------------------------------------------------------------
  // Retention regulator overrides
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < RET_N; i++) begin : g_ret
    assign retention_out.ldo_enable[i] = override_q[2*i] | sm_retention.ldo_enable[i];
    assign retention_out.vref_hold[i]  = override_q[2*i+1] | sm_retention.vref_hold[i];
  end

  // ----------------------------------------------------------------------
  // Rail discharge
  // ----------------------------------------------------------------------
  wire logic [RAIL_N-1:0] rail_auto_now;

  assign rail_auto_now  = rail_auto_q & {RAIL_N{pin_reset_active}};
  assign rail_discharge = rail_discharge_t'(rail_now_q | rail_auto_now);

  // ----------------------------------------------------------------------
  // Security and interrupt outputs
  // ----------------------------------------------------------------------
  assign debug_port_allow          = ~secure_q[SEC_DEBUG_BLOCK] & debugger_enable;
  assign secure_boot_supported     = secure_q[SEC_AUTH_BOOT];
  assign crystal_settled_interrupt = |(irq_status_q & irq_mask_q);

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  wire  logic [DECODE_W-1:0] rd_idx;
  logic [REG_W-1:0]          rd_val;
  logic                      rd_hit;

  assign rd_idx = s_axi_araddr[DECODE_LSB +: DECODE_W];

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (rd_idx == CRYSTAL_READY_DELAY_IDX[DECODE_W-1:0]) begin
      rd_val[DELAY_W-1:0] = crystal_settle_count_q;
    end else if (rd_idx == RETENTION_REG_OVERRIDE_IDX[DECODE_W-1:0]) begin
      rd_val[OVR_W-1:0] = override_q;
    end else if (rd_idx == RESET_CAUSE_FLAGS_IDX[DECODE_W-1:0]) begin
      rd_val[CAUSE_W-1:0] = cause_q;
    end else if (rd_idx == BOOT_SECURITY_FLAGS_IDX[DECODE_W-1:0]) begin
      rd_val[SECURE_W-1:0] = secure_q;
    end else if (rd_idx == RAIL_AUTO_DISCHARGE_IDX[DECODE_W-1:0]) begin
      rd_val[RAIL_N-1:0] = rail_auto_q;
    end else if (rd_idx == RAIL_IMMEDIATE_DISCHARGE_IDX[DECODE_W-1:0]) begin
      rd_val[RAIL_N-1:0] = rail_now_q;
    end else if (rd_idx == IRQ_STATUS_IDX[DECODE_W-1:0]) begin
      rd_val[IRQ_W-1:0] = irq_status_q;
    end else if (rd_idx == IRQ_MASK_IDX[DECODE_W-1:0]) begin
      rd_val[IRQ_W-1:0] = irq_mask_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite responses
  // ----------------------------------------------------------------------
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {{(32-REG_W){1'b0}}, rd_val};
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// ===== rtl/pmu_reset_retention_pkg.sv
/*
  Package for the power-management reset and retention control block:
  register indices, field layouts, reset values and the packed carriers.
  Assumes a 32-bit AXI4-Lite register bus and a 16-bit register file.
*/
package pmu_reset_retention_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the low index bits)
  // ----------------------------------------------------------------------
  localparam logic [31:0] CRYSTAL_READY_DELAY_IDX      = 32'h5000_0050;
  localparam logic [31:0] RETENTION_REG_OVERRIDE_IDX   = 32'h5000_0054;
  localparam logic [31:0] RESET_CAUSE_FLAGS_IDX        = 32'h5000_005e;
  localparam logic [31:0] BOOT_SECURITY_FLAGS_IDX      = 32'h5000_0066;
  localparam logic [31:0] RAIL_AUTO_DISCHARGE_IDX      = 32'h5000_0068;
  localparam logic [31:0] RAIL_IMMEDIATE_DISCHARGE_IDX = 32'h5000_006a;
  localparam logic [31:0] IRQ_STATUS_IDX               = 32'h5000_0070;
  localparam logic [31:0] IRQ_MASK_IDX                 = 32'h5000_0071;

  localparam int unsigned DECODE_LSB = 2;
  localparam int unsigned DECODE_W   = 8;

  // ----------------------------------------------------------------------
  // Field widths and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned REG_W     = 16;
  localparam int unsigned DELAY_W   = 8;
  localparam int unsigned RET_N     = 3;
  localparam int unsigned OVR_W     = 2 * RET_N;
  localparam int unsigned CAUSE_W   = 5;
  localparam int unsigned SECURE_W  = 2;
  localparam int unsigned RAIL_N    = 3;
  localparam int unsigned IRQ_W     = 1;

  localparam logic [DELAY_W-1:0]  DELAY_RST    = 8'h00;
  localparam logic [DELAY_W-1:0]  DELAY_NO_IRQ = 8'h00;
  localparam logic [OVR_W-1:0]    OVR_RST      = 6'h00;
  localparam logic [CAUSE_W-1:0]  CAUSE_RST    = 5'h1f;
  localparam logic [SECURE_W-1:0] SECURE_RST   = 2'h0;
  localparam logic [RAIL_N-1:0]   RAIL_RST     = 3'h0;
  localparam logic [IRQ_W-1:0]    IRQ_RST      = 1'h0;

  // Reset cause bit positions
  localparam int unsigned CAUSE_POWER_ON = 0;
  localparam int unsigned CAUSE_PIN      = 1;
  localparam int unsigned CAUSE_SOFTWARE = 2;
  localparam int unsigned CAUSE_WATCHDOG = 3;
  localparam int unsigned CAUSE_DEBUG    = 4;

  // Boot security bit positions
  localparam int unsigned SEC_AUTH_BOOT    = 0;
  localparam int unsigned SEC_DEBUG_BLOCK  = 1;

  // Interrupt status bit positions
  localparam int unsigned IRQ_CRYSTAL = 0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  // Index 2 amp, 1 storage, 0 battery
  typedef struct packed {
    logic [RET_N-1:0] ldo_enable;
    logic [RET_N-1:0] vref_hold;
  } retention_ctrl_t;

  // Index 2 amp rail, 1 io rail, 0 core rail
  typedef struct packed {
    logic amp_rail_discharge;
    logic io_rail_discharge;
    logic core_rail_discharge;
  } rail_discharge_t;

  typedef struct packed {
    logic pin_reset;
    logic software_reset;
    logic watchdog_reset;
    logic debug_reset_request;
  } reset_events_t;

endpackage

// ===== verification/pmu_reset_retention_ctrl_bench.sv
/*
  Self-checking bench for the reset and retention control block.
  Assumes the package, the block and its checker are compiled first.
*/
`timescale 1ns/1ps

module pmu_reset_retention_ctrl_bench;
  import pmu_reset_retention_pkg::*;
  logic            aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready, lp_tick, xtal_en, pin_rst, dbg_en, allow, secure, irq;
  logic [31:0]     awaddr, wdata, araddr, rdata;
  logic [1:0]      bresp, rresp;
  retention_ctrl_t sm, ret;
  reset_events_t   ev;
  rail_discharge_t rail;
  int              err_total, num_checks;
  logic [33:0]     rq[$];
  logic [1:0]      bq[$];
  logic [5:0]      o;
  logic [4:0]      c;
  logic [2:0]      m;

  pmu_reset_retention_ctrl uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .lp_tick(lp_tick), .crystal_enable(xtal_en), .sm_retention(sm), .retention_out(ret),
    .reset_events(ev), .pin_reset_active(pin_rst), .rail_discharge(rail), .debugger_enable(dbg_en),
    .debug_port_allow(allow), .secure_boot_supported(secure), .crystal_settled_interrupt(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic summarize();
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [33:0] x, input logic [33:0] g);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask

  // Responses are compared against the oldest expectation as they appear
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) chk("read", rq.pop_front(), {rresp, rdata});
    if (bvalid === 1'b1 && bready === 1'b1) chk("bresp", bq.pop_front(), bresp);
  end

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (s !== 1'b1 && n < 50);
    if (s !== 1'b1) begin
      err_total++;
      summarize();
    end
  endtask

  task automatic wr(input logic [31:0] idx, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= idx << 2;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wait_hi(awready);
    chk("write ready", 1'b1, wready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wait_hi(bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] idx, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    rq.push_back({r, d});
    araddr <= idx << 2;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wait_hi(arready);
    arvalid <= 1'b0;
    wait_hi(rvalid);
    rready <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge aclk);
      lp_tick <= 1'b1;
      @(posedge aclk);
      lp_tick <= 1'b0;
    end
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    err_total++;
    summarize();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, lp_tick, xtal_en, pin_rst, dbg_en} = '0;
    {awaddr, wdata, araddr, sm, ev} = '0;
    void'($urandom(69));
    do_reset();
    rd(CRYSTAL_READY_DELAY_IDX, 32'h0, RESP_OKAY);
    rd(RETENTION_REG_OVERRIDE_IDX, 32'h0, RESP_OKAY);
    rd(RESET_CAUSE_FLAGS_IDX, 32'h1f, RESP_OKAY);
    rd(BOOT_SECURITY_FLAGS_IDX, 32'h0, RESP_OKAY);
    rd(RAIL_AUTO_DISCHARGE_IDX, 32'h0, RESP_OKAY);
    rd(RAIL_IMMEDIATE_DISCHARGE_IDX, 32'h0, RESP_OKAY);
    rd(32'h5000_0060, 32'h0, RESP_SLVERR);
    wr(32'h5000_0060, 32'hffff, RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      o = 6'($urandom);
      wr(RETENTION_REG_OVERRIDE_IDX, {26'h0, o}, RESP_OKAY);
      sm <= 6'($urandom);
      repeat (2) @(posedge aclk);
      chk("regulator enable", {o[4], o[2], o[0]} | sm.ldo_enable, ret.ldo_enable);
      chk("reference hold", {o[5], o[3], o[1]} | sm.vref_hold, ret.vref_hold);
      rd(RETENTION_REG_OVERRIDE_IDX, {26'h0, o}, RESP_OKAY);
    end
    wr(RETENTION_REG_OVERRIDE_IDX, 32'h15, RESP_OKAY);
    sm <= 6'h00;
    repeat (2) @(posedge aclk);
    chk("active mode", 6'h38, ret);
    wr(RESET_CAUSE_FLAGS_IDX, 32'h0, RESP_OKAY);
    c = 5'h00;
    for (int i = 0; i < 4; i++) begin
      ev <= 4'h8 >> i;
      @(posedge aclk);
      ev <= 4'h0;
      c = c | (5'h02 << i);
      rd(RESET_CAUSE_FLAGS_IDX, {27'h0, c}, RESP_OKAY);
    end
    dbg_en <= 1'b1;
    wr(BOOT_SECURITY_FLAGS_IDX, 32'h1, RESP_OKAY);
    wr(BOOT_SECURITY_FLAGS_IDX, 32'h0, RESP_OKAY);
    rd(BOOT_SECURITY_FLAGS_IDX, 32'h1, RESP_OKAY);
    chk("secure boot", 1'b1, secure);
    chk("debug allow", 1'b1, allow);
    wr(BOOT_SECURITY_FLAGS_IDX, 32'h2, RESP_OKAY);
    chk("debug allow", 1'b0, allow);
    rd(BOOT_SECURITY_FLAGS_IDX, 32'h3, RESP_OKAY);
    do_reset();
    rd(BOOT_SECURITY_FLAGS_IDX, 32'h0, RESP_OKAY);
    rd(RESET_CAUSE_FLAGS_IDX, 32'h1f, RESP_OKAY);
    chk("debug allow", 1'b1, allow);
    chk("secure boot", 1'b0, secure);
    for (int i = 0; i < 16; i++) begin
      m = 3'($urandom);
      wr(RAIL_AUTO_DISCHARGE_IDX, i & 7, RESP_OKAY);
      wr(RAIL_IMMEDIATE_DISCHARGE_IDX, {29'h0, m}, RESP_OKAY);
      pin_rst <= i[3];
      repeat (2) @(posedge aclk);
      chk("rail discharge", m | (i[2:0] & {3{i[3]}}), rail);
    end
    pin_rst <= 1'b0;
    wr(RAIL_IMMEDIATE_DISCHARGE_IDX, 32'h0, RESP_OKAY);
    wr(CRYSTAL_READY_DELAY_IDX, 32'h3, RESP_OKAY);
    xtal_en <= 1'b1;
    wr(IRQ_MASK_IDX, 32'h1, RESP_OKAY);
    ticks(2);
    chk("settled interrupt", 1'b0, irq);
    ticks(1);
    chk("settled interrupt", 1'b1, irq);
    rd(IRQ_STATUS_IDX, 32'h1, RESP_OKAY);
    wr(IRQ_MASK_IDX, 32'h0, RESP_OKAY);
    chk("masked interrupt", 1'b0, irq);
    wr(IRQ_STATUS_IDX, 32'h1, RESP_OKAY);
    ticks(4);
    rd(IRQ_STATUS_IDX, 32'h0, RESP_OKAY);
    xtal_en <= 1'b0;
    wr(CRYSTAL_READY_DELAY_IDX, 32'h0, RESP_OKAY);
    xtal_en <= 1'b1;
    wr(IRQ_MASK_IDX, 32'h1, RESP_OKAY);
    ticks(256);
    chk("settled interrupt", 1'b0, irq);
    rd(IRQ_STATUS_IDX, 32'h0, RESP_OKAY);
    summarize();
  end
endmodule

// ===== verification/pmu_reset_retention_monitor.sv
/*
  Port checker for the reset and retention control block.
  Assumes it is bound into every instance of pmu_reset_retention_ctrl.
*/
`timescale 1ns/1ps

module pmu_reset_retention_monitor
  import pmu_reset_retention_pkg::*;
(
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_rvalid,
  input wire logic            lp_tick,
  input wire logic            crystal_enable,
  input wire retention_ctrl_t sm_retention,
  input wire retention_ctrl_t retention_out,
  input wire logic            pin_reset_active,
  input wire rail_discharge_t rail_discharge,
  input wire logic            debugger_enable,
  input wire logic            debug_port_allow,
  input wire logic            secure_boot_supported,
  input wire logic            crystal_settled_interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ldo_or;
    (retention_out.ldo_enable & sm_retention.ldo_enable) == sm_retention.ldo_enable;
  endproperty
  a_ldo_or: assert property (p_ldo_or) else $error("regulator enable dropped");
  property p_hold_or;
    (retention_out.vref_hold & sm_retention.vref_hold) == sm_retention.vref_hold;
  endproperty
  a_hold_or: assert property (p_hold_or) else $error("reference hold dropped");
  property p_dbg_block;
    debug_port_allow |-> debugger_enable;
  endproperty
  a_dbg_block: assert property (p_dbg_block) else $error("debug allowed while disabled");
  property p_block_sticky;
    debugger_enable && !debug_port_allow |=> !debug_port_allow;
  endproperty
  a_block_sticky: assert property (p_block_sticky) else $error("debug block released");
  property p_boot_sticky;
    secure_boot_supported |=> secure_boot_supported;
  endproperty
  a_boot_sticky: assert property (p_boot_sticky) else $error("secure boot flag cleared");
  property p_reset_out;
    $rose(aresetn) |-> rail_discharge == 3'h0 && !secure_boot_supported && !crystal_settled_interrupt
      && debug_port_allow == debugger_enable;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
  property p_irq_cause;
    $rose(crystal_settled_interrupt) |-> $past(crystal_enable) && ($past(lp_tick) || $past(lp_tick, 2))
      || $past(s_axi_awvalid && s_axi_awready);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without tick");
  property p_rail_cause;
    (rail_discharge & ~$past(rail_discharge)) != 3'h0 |-> pin_reset_active || $past(s_axi_awvalid && s_axi_awready);
  endproperty
  a_rail_cause: assert property (p_rail_cause) else $error("discharge without cause");
  property p_wr_answer;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_rd_answer;
    s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response late");
endmodule

bind pmu_reset_retention_ctrl pmu_reset_retention_monitor mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_rvalid(s_axi_rvalid), .lp_tick(lp_tick), .crystal_enable(crystal_enable),
  .sm_retention(sm_retention), .retention_out(retention_out), .pin_reset_active(pin_reset_active),
  .rail_discharge(rail_discharge), .debugger_enable(debugger_enable), .debug_port_allow(debug_port_allow),
  .secure_boot_supported(secure_boot_supported), .crystal_settled_interrupt(crystal_settled_interrupt)
);
